// >>> design/itp_pkg.sv
// constants, types and register map of the tag memory test port controller
package itp_pkg;
  // ------------------------------------------------------------
  // widths and sizes
  // ------------------------------------------------------------
  localparam int ADDR_W  = 13;
  localparam int DATA_W  = 32;
  localparam int CNT_W   = 12;
  localparam int MAX_LOC = 2048;
  localparam int PIPE_D  = 9;
  // ------------------------------------------------------------
  // timing counts in ref_clk cycles
  // ------------------------------------------------------------
  localparam int RST_HOLD_CYC = 6;
  localparam int SETTLE_CYC   = 8;
  localparam int WR_STRB_CYC  = 3;
  localparam int ILV_PRE_CYC  = 3;
  localparam int CMP_HIT_LAT  = 3;
  localparam int KTA_HIT_LAT  = 4;
  localparam int KTA_DATA_LAT = 6;
  localparam int SYNC_LAT     = 2;
  // ------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BASE   = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_TAGPAT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_HITCNT = 8'h14;
  localparam logic [7:0] OFF_MISCNT = 8'h18;
  localparam logic [7:0] OFF_LASTRD = 8'h1c;
  localparam logic [7:0] OFF_STRIDE = 8'h20;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_CLR_BIT   = 4;
  localparam int TAG_VALID_BIT  = 8;
  localparam logic [ADDR_W-1:0] BASE_RST   = 13'h0000;
  localparam logic [ADDR_W-1:0] STRIDE_RST = 13'h0001;
  localparam logic [CNT_W-1:0]  COUNT_RST  = 12'h001;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ENTER = 3'h0, OP_TAG_WR = 3'h1, OP_TAG_CMP = 3'h2, OP_ILV = 3'h3, OP_KTA = 3'h4
  } itp_op_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ENTRY = 3'b001, S_RESET = 3'b011,
    S_SETTLE = 3'b010, S_RUN = 3'b110, S_DRAIN = 3'b111
  } itp_state_e;
  typedef struct packed {
    logic [ADDR_W-1:0] testAddr;
    logic              addrLatch;
    logic              tagArrayWriteStrobe;
    logic              parallelTagDataRead;
    logic              memTestEnable;
    logic              arrayCaptureEnable;
    logic              arrayWriteBlock;
    logic              ioRingScanSelect;
    logic              coreResetN;
    logic [DATA_W-1:0] coreReadDataBus;
  } itp_pins_s;
  typedef struct packed {
    logic              cacheHitFlag;
    logic [DATA_W-1:0] coreWriteDataBus;
  } itp_obs_s;
  typedef struct packed {
    itp_state_e        st;
    itp_op_e           op;
    logic [15:0]       cnt;
    logic [CNT_W-1:0]  idx;
    logic [1:0]        phase;
    logic              inTest;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] stride;
    logic [CNT_W-1:0]  count;
    logic [DATA_W-1:0] tagPat;
    logic [15:0]       hitCnt;
    logic [15:0]       missCnt;
    logic [DATA_W-1:0] lastData;
    logic [PIPE_D-1:0] expHit;
    logic [PIPE_D-1:0] expData;
    itp_pins_s         pins;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic              arready;
    logic              rvalid;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic              awHave;
    logic              wHave;
    logic [7:0]        awAddr;
    logic [DATA_W-1:0] wData;
    logic [3:0]        wStrb;
  } itp_ctl_s;
  localparam itp_pins_s PINS_RST = '{coreResetN: 1'b1, default: '0};
  localparam itp_ctl_s CTL_RST = '{st: S_IDLE, op: OP_ENTER, base: BASE_RST,
    stride: STRIDE_RST, count: COUNT_RST, pins: PINS_RST, awready: 1'b1,
    wready: 1'b1, arready: 1'b1, default: '0};
endpackage

// >>> design/itp_sync.sv
// two flip-flop synchroniser for pin inputs
module itp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [1:0][W-1:0] stage_r;
  logic [1:0][W-1:0] stage_nxt;

  always_comb begin
    stage_nxt = {stage_r[0], d};
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign q = stage_r[1];
endmodule

// >>> design/itp_tester.sv
// host tester driving the instruction-cache tag memory test port
// Behaviour
// [RULE1] device writes an array four cycles after address and data applied
// [RULE2] write pipeline takes a new address and data every cycle
// [RULE3] device shows read data on write-data bus six cycles after address
// [RULE4] parallel read: hit flag four cycles later, data two cycles after that
// [RULE5] hold core reset at least six cycles, then wait eight before sequences
// [RULE6] entry: enables high, latch, write block, scan select low, then reset
// [RULE7] keep enables high and write block, scan select low during all sequences
// [RULE8] tag path reaches each location individually, up to 2K
// [RULE9] device samples inputs and changes outputs on rising clock edges
// [RULE10] tag write: address C1 with latch, data lags one, strobe from C4
// [RULE11] each data word belongs to the address one cycle earlier
// [RULE12] tag value is upper tag bits with valid bit eight set
// [RULE13] tag read compares expected value; hit only on equal and valid
// [RULE14] compare burst: first read in C4, hit belongs to address three back
// [RULE15] three stall cycles with latch low after a compare burst
// [RULE16] interleave repeats stall, write, read; strobe low only in write
// [RULE17] address in stall and read cycles, data in write and stall cycles
// [RULE18] interleave start: strobe C1-C4, data C2, next address C4, low C5
// [RULE19] device captures the test address on the edge after latch asserted
// [RULE20] write block input suppresses array write strobes
// [RULE21] core stays idle in memory test mode
// [RULE22] hit flag stays low on mismatch or clear valid bit
module itp_tester #(
  parameter int RST_HOLD = itp_pkg::RST_HOLD_CYC,
  parameter int SETTLE   = itp_pkg::SETTLE_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  output itp_pkg::itp_pins_s       pinsOut,
  input  wire itp_pkg::itp_obs_s   obsIn
);
  itp_pkg::itp_ctl_s r;
  itp_pkg::itp_ctl_s n;
  itp_pkg::itp_obs_s obs;
  logic [31:0]       tagW;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] v,
                                         input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) m[8*b +: 8] = v[8*b +: 8];
    end
    return m;
  endfunction

  function automatic logic [12:0] addrOf(input logic [12:0] b, input logic [12:0] s,
                                        input logic [11:0] i);
    logic [24:0] p;
    p = 25'(i) * 25'(s) + 25'(b);
    return p[12:0];
  endfunction

  function automatic logic [3:0] tapOf(input itp_pkg::itp_op_e o);
    logic [3:0] t;
    t = 4'h0;
    case (o)
      itp_pkg::OP_TAG_CMP: t = 4'(itp_pkg::CMP_HIT_LAT + itp_pkg::SYNC_LAT); // RULE14
      itp_pkg::OP_ILV:     t = 4'(itp_pkg::SYNC_LAT); // RULE16
      itp_pkg::OP_KTA:     t = 4'(itp_pkg::KTA_HIT_LAT + itp_pkg::SYNC_LAT); // RULE4
      default:             t = 4'h0;
    endcase
    return t;
  endfunction

  // ------------------------------------------------------------
  // pin input synchronisation
  // ------------------------------------------------------------
  itp_sync #(.W($bits(itp_pkg::itp_obs_s))) u_sync ( // RULE9
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .d       (obsIn),
    .q       (obs)
  );

  // tag word with valid bit set
  assign tagW = {r.tagPat[31:itp_pkg::TAG_VALID_BIT+1], 1'b1, // RULE12
                 r.tagPat[itp_pkg::TAG_VALID_BIT-1:0]};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic       startReq;
    logic       clrCnt;
    logic [3:0] tap;
    logic [7:0] wa;
    logic [7:0] ra;
    startReq = 1'b0;
    clrCnt   = 1'b0;
    tap      = tapOf(r.op);
    wa       = {r.awAddr[7:2], 2'b00};
    ra       = {araddr[7:2], 2'b00};
    n        = r;
    n.expHit  = {r.expHit[itp_pkg::PIPE_D-2:0], 1'b0};
    n.expData = {r.expData[itp_pkg::PIPE_D-2:0], 1'b0};
    // bus write side
    if (r.awready && awvalid) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (r.wready && wvalid) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (r.bvalid && bready) n.bvalid = 1'b0;
    if (r.awHave && r.wHave && !r.bvalid) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = itp_pkg::RESP_OKAY;
      case (wa)
        itp_pkg::OFF_CTRL: begin
          startReq = r.wStrb[0] && r.wData[itp_pkg::CTRL_START_BIT];
          clrCnt   = r.wStrb[0] && r.wData[itp_pkg::CTRL_CLR_BIT];
        end
        itp_pkg::OFF_BASE:   n.base   = 13'(wmerge(32'(r.base), r.wData, r.wStrb));
        itp_pkg::OFF_STRIDE: n.stride = 13'(wmerge(32'(r.stride), r.wData, r.wStrb));
        itp_pkg::OFF_COUNT:  n.count  = 12'(wmerge(32'(r.count), r.wData, r.wStrb));
        itp_pkg::OFF_TAGPAT: n.tagPat = wmerge(r.tagPat, r.wData, r.wStrb);
        default:             n.bresp  = itp_pkg::RESP_SLVERR;
      endcase
    end
    n.awready = !n.awHave;
    n.wready  = !n.wHave;
    // bus read side
    if (r.rvalid && rready) n.rvalid = 1'b0;
    if (r.arready && arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = itp_pkg::RESP_OKAY;
      case (ra)
        itp_pkg::OFF_CTRL:   n.rdata = {28'h0000000, 1'b0, r.op};
        itp_pkg::OFF_BASE:   n.rdata = 32'(r.base);
        itp_pkg::OFF_STRIDE: n.rdata = 32'(r.stride);
        itp_pkg::OFF_COUNT:  n.rdata = 32'(r.count);
        itp_pkg::OFF_TAGPAT: n.rdata = r.tagPat;
        itp_pkg::OFF_STATUS: n.rdata = {30'h00000000, r.inTest, r.st != itp_pkg::S_IDLE};
        itp_pkg::OFF_HITCNT: n.rdata = 32'(r.hitCnt);
        itp_pkg::OFF_MISCNT: n.rdata = 32'(r.missCnt);
        itp_pkg::OFF_LASTRD: n.rdata = r.lastData;
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = itp_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;
    // result counters, a clear and a hardware event in one cycle leave a count of one
    if (clrCnt) begin
      n.hitCnt  = 16'h0000;
      n.missCnt = 16'h0000;
    end
    if (r.expHit[tap]) begin
      if (obs.cacheHitFlag) n.hitCnt = n.hitCnt + 16'h0001; // RULE13
      else n.missCnt = n.missCnt + 16'h0001; // RULE22
    end
    if (r.expData[itp_pkg::PIPE_D-1]) n.lastData = obs.coreWriteDataBus; // RULE3
    // sequencer
    unique case (r.st)
      itp_pkg::S_IDLE: begin
        if (startReq) begin
          n.op    = itp_pkg::itp_op_e'(r.wData[itp_pkg::CTRL_OP_LSB +: 3]);
          n.cnt   = 16'h0000;
          n.idx   = '0;
          n.phase = 2'h0;
          if (n.op == itp_pkg::OP_ENTER) begin
            n.st = itp_pkg::S_ENTRY;
            n.inTest = 1'b0;
            n.pins.memTestEnable       = 1'b1; // RULE6
            n.pins.arrayCaptureEnable  = 1'b1;
            n.pins.addrLatch           = 1'b0;
            n.pins.arrayWriteBlock     = 1'b0; // RULE7 RULE20
            n.pins.ioRingScanSelect    = 1'b0;
            n.pins.tagArrayWriteStrobe = 1'b0;
            n.pins.parallelTagDataRead = 1'b0;
          end else if (r.inTest && r.count != '0 && n.op <= itp_pkg::OP_KTA) begin
            n.st = itp_pkg::S_RUN;
          end
        end
      end
      itp_pkg::S_ENTRY: begin
        n.pins.coreResetN = 1'b0; // RULE6
        n.st = itp_pkg::S_RESET;
      end
      itp_pkg::S_RESET: begin
        n.cnt = r.cnt + 16'h0001;
        if (r.cnt == 16'(RST_HOLD - 1)) begin
          n.pins.coreResetN = 1'b1; // RULE5
          n.cnt = 16'h0000;
          n.st  = itp_pkg::S_SETTLE;
        end
      end
      itp_pkg::S_SETTLE: begin
        n.cnt = r.cnt + 16'h0001;
        if (r.cnt == 16'(SETTLE - 1)) begin
          n.inTest = 1'b1; // RULE21
          n.st     = itp_pkg::S_IDLE; // RULE5
        end
      end
      itp_pkg::S_RUN: begin
        n.cnt = r.cnt + 16'h0001;
        n.pins.addrLatch = 1'b0;
        n.pins.coreReadDataBus = tagW; // RULE11
        case (r.op)
          itp_pkg::OP_TAG_WR: begin
            if (r.cnt < 16'(r.count)) begin
              n.pins.addrLatch = 1'b1; // RULE10
              n.pins.testAddr  = addrOf(r.base, r.stride, r.cnt[11:0]); // RULE2
            end
            n.pins.tagArrayWriteStrobe = r.cnt >= 16'(itp_pkg::WR_STRB_CYC); // RULE10
            if (r.cnt == 16'(r.count) + 16'(itp_pkg::WR_STRB_CYC)) begin
              n.st  = itp_pkg::S_DRAIN; // RULE1
              n.cnt = 16'h0000;
            end
          end
          itp_pkg::OP_TAG_CMP, itp_pkg::OP_KTA: begin
            n.pins.addrLatch = 1'b1; // RULE19
            n.pins.testAddr  = addrOf(r.base, r.stride, r.cnt[11:0]); // RULE8
            n.pins.parallelTagDataRead = r.op == itp_pkg::OP_KTA; // RULE4
            n.expHit[0]  = 1'b1; // RULE14
            n.expData[0] = r.op == itp_pkg::OP_KTA;
            if (r.cnt == 16'(r.count) - 16'h0001) begin
              n.st  = itp_pkg::S_DRAIN; // RULE15
              n.cnt = 16'h0000;
            end
          end
          itp_pkg::OP_ILV: begin
            if (r.cnt < 16'(itp_pkg::ILV_PRE_CYC)) begin
              n.pins.tagArrayWriteStrobe = 1'b1; // RULE18
              n.pins.testAddr  = addrOf(r.base, r.stride, 12'h000);
              n.pins.addrLatch = r.cnt != 16'h0001;
            end else begin
              n.phase = (r.phase == 2'h2) ? 2'h0 : r.phase + 2'h1;
              case (r.phase)
                2'h0: begin
                  n.pins.testAddr  = addrOf(r.base, r.stride, r.idx + 12'h001); // RULE17
                  n.pins.addrLatch = 1'b1;
                  n.pins.tagArrayWriteStrobe = 1'b1; // RULE16
                end
                2'h1: n.pins.tagArrayWriteStrobe = 1'b0; // RULE16
                default: begin
                  n.pins.addrLatch = 1'b1; // RULE17
                  n.pins.tagArrayWriteStrobe = 1'b1;
                  n.expHit[0] = 1'b1; // RULE16
                  n.idx = r.idx + 12'h001;
                  if (r.idx == r.count - 12'h001) begin
                    n.st  = itp_pkg::S_DRAIN;
                    n.cnt = 16'h0000;
                  end
                end
              endcase
            end
          end
          default: n.st = itp_pkg::S_IDLE;
        endcase
      end
      itp_pkg::S_DRAIN: begin
        n.cnt = r.cnt + 16'h0001;
        n.pins.addrLatch           = 1'b0; // RULE15
        n.pins.tagArrayWriteStrobe = 1'b0;
        n.pins.parallelTagDataRead = 1'b0;
        if (r.cnt >= ((r.op == itp_pkg::OP_KTA) ? 16'(itp_pkg::PIPE_D - 1) : 16'(tap))) begin
          n.st = itp_pkg::S_IDLE;
        end
      end
      default: n.st = itp_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= itp_pkg::CTL_RST;
    end else begin
      r <= n;
    end
  end

  assign awready = r.awready;
  assign wready  = r.wready;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign arready = r.arready;
  assign rvalid  = r.rvalid;
  assign rresp   = r.rresp;
  assign rdata   = r.rdata;
  assign pinsOut = r.pins;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_reset_hold: assert property ( // RULE5
    $fell(r.pins.coreResetN) |-> !r.pins.coreResetN [*6]) else $error("core reset short");
  a_settle_gap: assert property ( // RULE5
    $rose(r.pins.coreResetN) |-> (r.st != itp_pkg::S_RUN) [*8]) else $error("settle short");
  a_entry_pins: assert property ( // RULE6
    $fell(r.pins.coreResetN) |-> (r.pins.memTestEnable && r.pins.arrayCaptureEnable &&
      !r.pins.addrLatch && !r.pins.arrayWriteBlock && !r.pins.ioRingScanSelect))
    else $error("entry pins wrong");
  a_test_pins: assert property ( // RULE7
    (r.st == itp_pkg::S_RUN) |-> (r.pins.memTestEnable && r.pins.arrayCaptureEnable &&
      !r.pins.arrayWriteBlock && !r.pins.ioRingScanSelect)) else $error("test pins wrong");
  a_wr_strobe: assert property ( // RULE10
    (r.st == itp_pkg::S_RUN && r.op == itp_pkg::OP_TAG_WR && r.cnt == 16'h0002) |=>
      !r.pins.tagArrayWriteStrobe ##1 r.pins.tagArrayWriteStrobe) else $error("strobe C4");
  a_data_follow: assert property ( // RULE11
    (r.st == itp_pkg::S_RUN && r.op == itp_pkg::OP_TAG_CMP && r.pins.addrLatch) |=>
      (r.pins.coreReadDataBus[itp_pkg::TAG_VALID_BIT] && r.pins.coreReadDataBus == tagW))
    else $error("expected data wrong");
  a_cmp_stall: assert property ( // RULE15
    (r.st == itp_pkg::S_RUN && r.op == itp_pkg::OP_TAG_CMP &&
      r.cnt == 16'(r.count) - 16'h0001) |=> r.pins.addrLatch ##1 !r.pins.addrLatch [*3])
    else $error("compare stall short");
  a_ilv_period: assert property ( // RULE16
    (r.st == itp_pkg::S_RUN && r.op == itp_pkg::OP_ILV && r.cnt >= 16'h0003 &&
      r.phase == 2'h0) |=> r.pins.tagArrayWriteStrobe ##1 !r.pins.tagArrayWriteStrobe
      ##1 r.pins.tagArrayWriteStrobe) else $error("interleave pattern");
  a_ilv_start: assert property ( // RULE18
    (r.st == itp_pkg::S_RUN && r.op == itp_pkg::OP_ILV && r.cnt == 16'h0000) |=>
      r.pins.tagArrayWriteStrobe [*4] ##1 !r.pins.tagArrayWriteStrobe)
    else $error("interleave start");
  a_resp_hold: assert property ( // bus write response held stable until accepted
    (r.bvalid && !bready) |=> (r.bvalid && $stable(r.bresp))) else $error("bvalid dropped");

  c_enter: cover property ($rose(r.inTest));
  c_cmp_done: cover property (r.st == itp_pkg::S_DRAIN && r.op == itp_pkg::OP_TAG_CMP
    ##1 r.st == itp_pkg::S_IDLE);
  c_ilv_hit: cover property (r.op == itp_pkg::OP_ILV && r.expHit[2] && obs.cacheHitFlag);
  c_kta_data: cover property (r.op == itp_pkg::OP_KTA && r.expData[itp_pkg::PIPE_D-1]);
endmodule

// >>> testbench/itp_tag_model.sv
// behavioural model of the tag array and read data path behind the test pins
module itp_tag_model (
  input  wire logic               ref_clk,
  input  wire itp_pkg::itp_pins_s pins,
  output itp_pkg::itp_obs_s       obs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // array and pipeline
  // ----------------------------------------
  logic [31:0] tags [2048] = '{default: 32'h0};
  logic [10:0] ap [5]      = '{default: 11'h0};
  logic [31:0] dp [2]      = '{default: 32'h0};
  logic [10:0] aHold       = 11'h0;
  logic [4:0]  kp          = 5'h0;
  logic        hitR        = 1'b0;
  logic [31:0] dataR       = 32'h0;
  logic [10:0] aCur;
  function automatic logic hitOf(input logic [10:0] a, input logic [31:0] d);
    return (tags[a] == d) && d[8];
  endfunction
  assign aCur = pins.addrLatch ? pins.testAddr[10:0] : aHold;
  assign obs  = '{cacheHitFlag: hitR, coreWriteDataBus: dataR};
  always @(posedge ref_clk) begin
    aHold <= aCur;
    ap    <= '{aCur, ap[0], ap[1], ap[2], ap[3]};
    dp    <= '{pins.coreReadDataBus, dp[0]};
    kp    <= {kp[3:0], pins.parallelTagDataRead};
    if (pins.tagArrayWriteStrobe && !pins.arrayWriteBlock) begin
      tags[ap[2]] <= dp[1];
    end
    hitR  <= kp[2] ? hitOf(ap[2], dp[1]) : hitOf(ap[1], dp[0]);
    dataR <= kp[4] ? {16'hc3c3, 5'h0, ap[4]} : ~dataR;
  end
endmodule

// >>> testbench/test_icache_tag_memory_test_port.sv
// self-checking bench of the tag memory test port controller
module test_icache_tag_memory_test_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk = 1'b0;
  logic               rst_b   = 1'b0;
  logic [7:0]         awaddr  = 8'h0;
  logic [7:0]         araddr  = 8'h0;
  logic [31:0]        wdata   = 32'h0;
  logic [3:0]         wstrb   = 4'h0;
  logic               awvalid = 1'b0;
  logic               wvalid  = 1'b0;
  logic               bready  = 1'b0;
  logic               arvalid = 1'b0;
  logic               rready  = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic [31:0]        curPat  = 32'h0;
  itp_pkg::itp_pins_s pinsOut;
  itp_pkg::itp_obs_s  obsIn;
  int                 numErrors = 0;
  int                 checkCount = 0;
  int                 lowCnt = 0;
  int                 gap = 0;
  always #10 ref_clk = ~ref_clk;
  itp_tester u_itp_tester (.ref_clk(ref_clk), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pinsOut(pinsOut), .obsIn(obsIn));
  itp_tag_model u_itp_tag_model (.ref_clk(ref_clk), .pins(pinsOut), .obs(obsIn));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict();
    if (numErrors == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bready && bvalid));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rready && rvalid));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic cfg(input logic [12:0] b, input logic [11:0] n, input logic [12:0] st,
                     input logic [31:0] pat);
    logic [1:0] r;
    curPat = pat;
    axw(itp_pkg::OFF_BASE, {19'h0, b}, r);
    axw(itp_pkg::OFF_COUNT, {20'h0, n}, r);
    axw(itp_pkg::OFF_STRIDE, {19'h0, st}, r);
    axw(itp_pkg::OFF_TAGPAT, pat, r);
    axw(itp_pkg::OFF_CTRL, 32'h10, r);
  endtask
  task automatic runOp(input itp_pkg::itp_op_e op);
    logic [31:0] s;
    logic [1:0]  r;
    axw(itp_pkg::OFF_CTRL, {28'h0, op, 1'b1}, r);
    chk(r, itp_pkg::RESP_OKAY);
    do axr(itp_pkg::OFF_STATUS, s, r); while (s[0]);
  endtask
  task automatic counts(input logic [31:0] h, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    axr(itp_pkg::OFF_HITCNT, d, r);
    chk(d, h);
    axr(itp_pkg::OFF_MISCNT, d, r);
    chk(d, m);
  endtask
  function automatic logic [31:0] dword(input logic [12:0] a);
    return {16'hc3c3, 5'h0, a[10:0]};
  endfunction
  // ----------------------------------------
  // pin monitor
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!pinsOut.coreResetN) begin
      lowCnt++;
      gap = 1;
    end else if (gap > 0 && !pinsOut.addrLatch) begin
      gap++;
    end else if (gap > 0) begin
      chk(lowCnt >= 6, 1'b1);
      chk(gap > 8, 1'b1);
      gap = 0;
    end
    if (pinsOut.addrLatch) begin
      chk({pinsOut.memTestEnable, pinsOut.arrayCaptureEnable, pinsOut.arrayWriteBlock,
           pinsOut.ioRingScanSelect}, 4'hc);
      chk(pinsOut.coreReadDataBus, {curPat[31:9], 1'b1, curPat[7:0]});
    end
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    numErrors++;
    giveVerdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [12:0] b, st;
    logic [11:0] n;
    logic [31:0] pat;
    d = $urandom(32'h8133);
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    axr(itp_pkg::OFF_COUNT, d, r);
    chk(d, {20'h0, itp_pkg::COUNT_RST});
    axr(itp_pkg::OFF_STRIDE, d, r);
    chk(d, {19'h0, itp_pkg::STRIDE_RST});
    axr(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, itp_pkg::RESP_SLVERR);
    axw(8'h44, 32'h1, r);
    chk(r, itp_pkg::RESP_SLVERR);
    runOp(itp_pkg::OP_ENTER);
    axr(itp_pkg::OFF_STATUS, d, r);
    chk(d, 32'h2);
    for (int i = 0; i < 6; i++) begin
      n   = (i == 0) ? 12'h1 : 12'($urandom_range(8, 1));
      st  = 13'($urandom_range(4, 1));
      b   = (i == 0) ? 13'h7ff : (i == 1) ? 13'h0 : 13'($urandom_range(2015, 0));
      pat = $urandom;
      cfg(b, n, st, pat);
      runOp(itp_pkg::OP_TAG_WR);
      runOp(itp_pkg::OP_TAG_CMP);
      counts(n, 0);
      cfg(b, n, st, pat ^ 32'h0010_0000);
      runOp(itp_pkg::OP_TAG_CMP);
      counts(0, n);
      cfg(b, n, st, pat);
      runOp(itp_pkg::OP_KTA);
      counts(n, 0);
      axr(itp_pkg::OFF_LASTRD, d, r);
      chk(d, dword(b + (n - 1) * st));
      chk(r, itp_pkg::RESP_OKAY);
      cfg(b, n, st, $urandom);
      runOp(itp_pkg::OP_ILV);
      counts(n, 0);
    end
    giveVerdict();
  end
endmodule
